//--- serial_boot_pkg.sv
// Constants for the serial boot loader: address map, framing, rates.
// Assumes one 100 MHz system clock and an active-low asynchronous reset.
//
// How it works
// - Mode bit0 high, bit1 low during reset selects serial boot at release.
// - In serial boot the boot ROM answers at FFF000H to FFFFFFH.
// - In serial boot the flash array answers at 10000H to 27FFFH.
// - Serial channel one runs UART, 8 data bits, no parity, one stop.
// - Rates 115200, 57600, 38400, 19200 and 9600 bit/s are selectable.
// - Password mismatch refuses the RAM transfer.
// - Erased flash makes the expected password twelve 0xFF bytes.
// - Routine is stored in RAM only inside 001000H to 001DFFH.
// - After the copy, execution jumps to the routine start.
// - Erase command wipes the whole flash without a routine.
// - Interrupts stay disabled; received bytes are found by polling flags.
// - Unused pins hold their post-reset default during serial boot.
package serial_boot_pkg;

  localparam int          CLK_HZ    = 100_000_000;
  localparam int          BAUD_BASE = 9600;
  localparam int          BASE_DIV  = CLK_HZ / BAUD_BASE;
  localparam int          BIT_W     = 14;
  localparam logic [3:0]  STOP_BIT  = 4'h9;
  localparam logic [23:0] ROM_LO    = 24'hff_f000;
  localparam logic [23:0] ROM_HI    = 24'hff_ffff;
  localparam logic [23:0] FLB_LO    = 24'h01_0000;
  localparam logic [23:0] FLB_HI    = 24'h02_7fff;
  localparam logic [23:0] FLN_LO    = 24'hfe_8000;
  localparam logic [23:0] FLN_HI    = 24'hff_ffff;
  localparam logic [23:0] RAM_LO    = 24'h00_1000;
  localparam logic [23:0] RAM_HI    = 24'h00_1dff;
  localparam logic [15:0] RAM_SPAN  = 16'h0e00;
  localparam logic [3:0]  PW_LAST   = 4'hb;
  localparam logic [7:0]  ERASED    = 8'hff;
  localparam logic [7:0]  CMD_LOAD  = 8'h30;
  localparam logic [7:0]  CMD_ERASE = 8'h40;
  localparam logic [7:0]  ACK       = 8'h06;
  localparam logic [7:0]  NAK       = 8'h15;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_CMD   = 4'b0001,
    S_PW    = 4'b0010,
    S_LEN0  = 4'b0011,
    S_LEN1  = 4'b0100,
    S_LOAD  = 4'b0101,
    S_JUMP  = 4'b0110,
    S_ERASE = 4'b0111,
    S_HALT  = 4'b1000
  } st_e;

endpackage

//--- serial_boot_loader.sv
// Serial boot loader: mode capture, address remap, UART link, loader FSM.
// Assumes synchronous pins, a RAM write port that can stall, and an
// external flash eraser that acknowledges with a done pulse.
`timescale 1ns/100ps
`default_nettype none
module serial_boot_loader
  import serial_boot_pkg::*;
#(
  parameter int DIV_9600 = BASE_DIV
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        mode_select_bit0_in,
  input  wire logic        mode_select_bit1_in,
  input  wire logic [2:0]  rate_sel_in,
  input  wire logic        serial_receive_line_in,
  input  wire logic        flash_erased_in,
  input  wire logic [95:0] app_password_in,
  input  wire logic [23:0] cpu_addr_in,
  input  wire logic        ram_ready_in,
  input  wire logic        erase_done_in,
  output logic             serial_transmit_line_out,
  output logic             boot_mode_out,
  output logic             rom_sel_out,
  output logic             flash_sel_out,
  output logic             int_enable_out,
  output logic             pin_hold_out,
  output logic             ram_wr_out,
  output logic [23:0]      ram_addr_out,
  output logic [7:0]       ram_data_out,
  output logic             jump_out,
  output logic [23:0]      jump_addr_out,
  output logic             chip_erase_out,
  output logic             overrun_out
);
  typedef struct packed {
    st_e              st;
    logic             armed;
    logic             boot;
    logic             rx_busy;
    logic [BIT_W-1:0] rx_cnt;
    logic [3:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic [1:0][7:0]  bq;
    logic [1:0]       bn;
    logic             bw;
    logic             br;
    logic             tx_busy;
    logic [BIT_W-1:0] tx_cnt;
    logic [3:0]       tx_bit;
    logic [9:0]       tx_sh;
    logic [3:0]       pw_i;
    logic             pw_bad;
    logic [15:0]      len;
    logic [15:0]      n;
    logic             txd;
    logic             rom_sel;
    logic             fl_sel;
    logic             int_en;
    logic             ram_wr;
    logic [23:0]      ram_addr;
    logic [7:0]       ram_data;
    logic             jump;
    logic [23:0]      jaddr;
    logic             erase;
    logic             overrun;
  } st_s;
  st_s r;
  st_s n;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [BIT_W-1:0] div_of(input logic [2:0] s);
    unique case (s)
      3'h0:    div_of = BIT_W'(DIV_9600);
      3'h1:    div_of = BIT_W'(DIV_9600 / 2);
      3'h2:    div_of = BIT_W'(DIV_9600 / 4);
      3'h3:    div_of = BIT_W'(DIV_9600 / 6);
      default: div_of = BIT_W'(DIV_9600 / 12);
    endcase
  endfunction
  function automatic logic in_rng(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction
  logic [BIT_W-1:0] div;
  logic             push;
  logic             pop;
  logic             take;
  logic [7:0]       head;
  logic [7:0]       expect_b;
  logic             tx_go;
  logic [7:0]       tx_byte;
  logic [15:0]      len16;
  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n        = r;
    n.ram_wr = 1'b0;
    n.jump   = 1'b0;
    n.erase  = 1'b0;
    div      = div_of(rate_sel_in);
    push     = 1'b0;
    tx_go    = 1'b0;
    tx_byte  = ACK;
    head     = r.bq[r.br];
    len16    = {head, r.len[7:0]};
    // Mode pins are caught on the first edge after release
    if (!r.armed) begin
      n.armed = 1'b1;
      n.boot  = mode_select_bit0_in & ~mode_select_bit1_in;
    end
    // Receiver: half-bit offset puts samples mid-cell
    if (!r.rx_busy) begin
      if (r.boot && !serial_receive_line_in) begin
        n.rx_busy = 1'b1;
        n.rx_cnt  = div >> 1;
        n.rx_bit  = 4'h0;
      end
    end else if (r.rx_cnt != '0) begin
      n.rx_cnt = r.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = div - 1'b1;
      n.rx_bit = r.rx_bit + 1'b1;
      if (r.rx_bit == 4'h0 && serial_receive_line_in) begin
        n.rx_busy = 1'b0;
      end else if (r.rx_bit == STOP_BIT) begin
        n.rx_busy = 1'b0;
        push      = serial_receive_line_in;
      end else if (r.rx_bit != 4'h0) begin
        n.rx_sh = {serial_receive_line_in, r.rx_sh[7:1]};
      end
    end
    // Loader polls the buffer flag instead of taking an interrupt
    unique case (r.st)
      S_CMD, S_PW, S_LEN0, S_LEN1: take = 1'b1;
      S_LOAD:  take = ram_ready_in;
      default: take = 1'b0;
    endcase
    pop = (r.bn != 2'd0) && take;
    expect_b = flash_erased_in ? ERASED : app_password_in[8*r.pw_i +: 8];
    // Loader sequence
    unique case (r.st)
      S_IDLE: begin
        if (r.armed) begin
          n.st = r.boot ? S_CMD : S_HALT;
        end
      end
      S_CMD: begin
        if (pop) begin
          if (head == CMD_LOAD) begin
            n.st     = S_PW;
            n.pw_i   = 4'h0;
            n.pw_bad = 1'b0;
          end else if (head == CMD_ERASE) begin
            n.erase = 1'b1;
            n.st    = S_ERASE;
          end else begin
            tx_go   = 1'b1;
            tx_byte = NAK;
          end
        end
      end
      S_PW: begin
        if (pop) begin
          n.pw_bad = r.pw_bad | (head != expect_b);
          n.pw_i   = r.pw_i + 1'b1;
          if (r.pw_i == PW_LAST) begin
            tx_go = 1'b1;
            if (n.pw_bad) begin
              tx_byte = NAK;
              n.st    = S_CMD;
            end else begin
              n.st = S_LEN0;
            end
          end
        end
      end
      S_LEN0: begin
        if (pop) begin
          n.len = {8'h00, head};
          n.st  = S_LEN1;
        end
      end
      S_LEN1: begin
        if (pop) begin
          tx_go = 1'b1;
          n.len = len16;
          n.n   = 16'h0000;
          // Routine longer than the window is refused outright
          if (len16 == 16'h0000 || len16 > RAM_SPAN) begin
            tx_byte = NAK;
            n.st    = S_CMD;
          end else begin
            n.st = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        if (pop) begin
          n.ram_wr   = 1'b1;
          n.ram_data = head;
          n.ram_addr = RAM_LO + {8'h00, r.n};
          n.n        = r.n + 1'b1;
          if (r.n + 1'b1 == r.len) begin
            n.st = S_JUMP;
          end
        end
      end
      S_JUMP: begin
        n.jump  = 1'b1;
        n.jaddr = RAM_LO;
        n.st    = S_HALT;
      end
      S_ERASE: begin
        if (erase_done_in) begin
          tx_go = 1'b1;
          n.st  = S_CMD;
        end
      end
      S_HALT:  n.st = S_HALT;
      default: n.st = S_IDLE;
    endcase
    // Two-entry buffer; a byte that meets a full buffer is flagged
    if (push && r.bn != 2'd2) begin
      n.bq[r.bw] = r.rx_sh;
      n.bw       = ~r.bw;
    end else if (push) begin
      n.overrun = 1'b1;
    end
    n.br = pop ? ~r.br : r.br;
    n.bn = r.bn + {1'b0, push && r.bn != 2'd2} - {1'b0, pop};
    // Transmitter; one answer per request, so it is never busy on go
    if (!r.tx_busy) begin
      n.txd = 1'b1;
      if (tx_go) begin
        n.tx_busy = 1'b1;
        n.tx_sh   = {1'b1, tx_byte, 1'b0};
        n.txd     = 1'b0;
        n.tx_bit  = 4'h0;
        n.tx_cnt  = div - 1'b1;
      end
    end else if (r.tx_cnt != '0) begin
      n.tx_cnt = r.tx_cnt - 1'b1;
    end else if (r.tx_bit == STOP_BIT) begin
      n.tx_busy = 1'b0;
      n.txd     = 1'b1;
    end else begin
      n.tx_sh  = r.tx_sh >> 1;
      n.txd    = r.tx_sh[1];
      n.tx_bit = r.tx_bit + 1'b1;
      n.tx_cnt = div - 1'b1;
    end
    // Address map follows the captured mode
    n.rom_sel = r.boot && in_rng(cpu_addr_in, ROM_LO, ROM_HI);
    n.fl_sel  = r.boot ? in_rng(cpu_addr_in, FLB_LO, FLB_HI)
                       : in_rng(cpu_addr_in, FLN_LO, FLN_HI);
    n.int_en  = r.armed && !r.boot;
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r     <= '0;
      r.txd <= 1'b1;
    end else begin
      r <= n;
    end
  end
  assign serial_transmit_line_out = r.txd;
  assign boot_mode_out            = r.boot;
  assign rom_sel_out              = r.rom_sel;
  assign flash_sel_out            = r.fl_sel;
  assign int_enable_out           = r.int_en;
  assign pin_hold_out             = r.boot;
  assign ram_wr_out               = r.ram_wr;
  assign ram_addr_out             = r.ram_addr;
  assign ram_data_out             = r.ram_data;
  assign jump_out                 = r.jump;
  assign jump_addr_out            = r.jaddr;
  assign chip_erase_out           = r.erase;
  assign overrun_out              = r.overrun;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_mode;
    !r.armed |=> boot_mode_out ==
      ($past(mode_select_bit0_in) && !$past(mode_select_bit1_in));
  endproperty
  a_mode: assert property (p_mode) else $error("mode capture");
  property p_rom;
    boot_mode_out && in_rng(cpu_addr_in, ROM_LO, ROM_HI) |=> rom_sel_out;
  endproperty
  a_rom: assert property (p_rom) else $error("boot rom map");
  property p_flash;
    boot_mode_out && in_rng(cpu_addr_in, FLB_LO, FLB_HI)
      |=> flash_sel_out && !rom_sel_out;
  endproperty
  a_flash: assert property (p_flash) else $error("flash remap");
  sequence s_start;
    tx_go && !r.tx_busy;
  endsequence
  sequence s_low;
    !serial_transmit_line_out [*2];
  endsequence
  property p_frame;
    s_start |=> s_low ##0 r.tx_sh[9];
  endproperty
  a_frame: assert property (p_frame) else $error("tx framing");
  property p_pw;
    r.st == S_PW && pop && r.pw_i == PW_LAST && n.pw_bad
      |=> r.st == S_CMD ##1 !ram_wr_out;
  endproperty
  a_pw: assert property (p_pw) else $error("password refuse");
  property p_erased;
    flash_erased_in && r.st == S_PW && pop && head != ERASED
      |=> r.pw_bad || r.st == S_CMD;
  endproperty
  a_erased: assert property (p_erased) else $error("erased pw");
  property p_ram;
    ram_wr_out |-> in_rng(ram_addr_out, RAM_LO, RAM_HI);
  endproperty
  a_ram: assert property (p_ram) else $error("ram window");
  property p_jump;
    r.st == S_JUMP |=> jump_out && jump_addr_out == RAM_LO;
  endproperty
  a_jump: assert property (p_jump) else $error("jump");
  property p_erase;
    r.st == S_CMD && pop && head == CMD_ERASE |=> chip_erase_out;
  endproperty
  a_erase: assert property (p_erase) else $error("chip erase");
  property p_int;
    r.armed && r.boot |=> !int_enable_out;
  endproperty
  a_int: assert property (p_int) else $error("int enabled");
endmodule // serial_boot_loader
`default_nettype wire

//--- uart_ctrl_model.sv
// Programming controller model: sends and receives UART characters.
// Assumes the bench sets div to the bit time in clock cycles.
`timescale 1ns/100ps
`default_nettype none
module uart_ctrl_model (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  int div = 48;
  initial line_out = 1'b1;
  // Low start, LSB first, no parity, one high stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (div) @(negedge clk_in);
    end
  endtask
  // Bounded wait for a start bit, then samples mid-bit
  task automatic recv(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 0;
    b = 8'h00;
    while (line_in !== 1'b0 && n < 200 * div) begin
      @(negedge clk_in);
      n++;
    end
    if (n < 200 * div) begin
      repeat (div / 2) @(negedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(negedge clk_in);
        b[i] = line_in;
      end
      repeat (div) @(negedge clk_in);
      ok = (line_in === 1'b1);
    end
  endtask
endmodule // uart_ctrl_model
`default_nettype wire

//--- tb_serial_boot_loader.sv
// Testbench for the serial boot loader.
// Assumes a short bit divider (48) so each character takes 480 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_serial_boot_loader;
  import serial_boot_pkg::*;
  // ****************************************************
  // Signals and instances
  // ****************************************************
  logic        ref_clk_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        m0, m1, erased, ready, edone;
  logic [2:0]  rate;
  logic [23:0] addr;
  logic        rxl, txl, boot, rom, fl, inten, hold, wr, jmp, ers, ovr;
  logic [23:0] wa, ja;
  logic [7:0]  wd;
  logic [23:0] qa[$];
  logic [7:0]  qd[$];
  int          n_errors = 0;
  int          checks   = 0;
  int          n_jump   = 0;
  int          n_erase  = 0;
  // Not all 0xFF, so only the erased flag can make twelve 0xFF pass
  localparam logic [95:0] PW = 96'h0123_4567_89ab_cdef_0011_2233;
  always #5 ref_clk_in = ~ref_clk_in;
  serial_boot_loader #(.DIV_9600(48)) DUT (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .mode_select_bit0_in(m0), .mode_select_bit1_in(m1),
    .rate_sel_in(rate), .serial_receive_line_in(rxl),
    .flash_erased_in(erased), .app_password_in(PW),
    .cpu_addr_in(addr), .ram_ready_in(ready), .erase_done_in(edone),
    .serial_transmit_line_out(txl), .boot_mode_out(boot),
    .rom_sel_out(rom), .flash_sel_out(fl), .int_enable_out(inten),
    .pin_hold_out(hold), .ram_wr_out(wr), .ram_addr_out(wa),
    .ram_data_out(wd), .jump_out(jmp), .jump_addr_out(ja),
    .chip_erase_out(ers), .overrun_out(ovr));
  uart_ctrl_model CTRL (.clk_in(ref_clk_in), .line_in(txl), .line_out(rxl));
  always @(posedge ref_clk_in) begin
    if (wr === 1'b1) begin
      qa.push_back(wa);
      qd.push_back(wd);
    end
    if (jmp === 1'b1) n_jump++;
    if (ers === 1'b1) n_erase++;
  end
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [23:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // Sends a byte and waits, bounded, for the reply character
  task automatic xfer(input logic [7:0] b, input logic [7:0] e);
    logic [7:0] r;
    bit ok;
    fork
      CTRL.send(b);
      CTRL.recv(r, ok);
    join
    chk_bit(ok, 1'b1, "reply framing");
    chk_word({16'h0000, r}, {16'h0000, e}, "reply byte");
    if (ok !== 1'b1) tally_and_finish();
  endtask
  task automatic send_pw(input int n);
    CTRL.send(CMD_LOAD);
    repeat (n) CTRL.send(8'hff);
  endtask
  task automatic do_reset();
    nrst_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_decode();
    logic [23:0] ta[7] = '{24'hff_f000, 24'hff_efff, 24'hff_ffff,
      24'h01_0000, 24'h02_7fff, 24'h02_8000, 24'h00_ffff};
    logic [1:0] te[7] = '{2'b10, 2'b00, 2'b10, 2'b01, 2'b01, 2'b00, 2'b00};
    chk_bit(boot, 1'b1, "boot mode");
    chk_bit(inten, 1'b0, "interrupts");
    chk_bit(hold, 1'b1, "pin hold");
    for (int i = 0; i < 7; i++) begin
      addr = ta[i];
      repeat (2) @(negedge ref_clk_in);
      chk_bit(rom, te[i][1], "rom decode");
      chk_bit(fl, te[i][0], "flash decode");
    end
  endtask
  task automatic t_erase();
    fork
      xfer(CMD_ERASE, ACK);
      begin
        for (int i = 0; i < 3000 && n_erase == 0; i++)
          @(negedge ref_clk_in);
        edone = 1'b1;
        @(negedge ref_clk_in);
        edone = 1'b0;
      end
    join
    chk_word(24'(n_erase), 24'h00_0001, "erase pulses");
  endtask
  task automatic t_load();
    erased = 1'b1;
    send_pw(12);
    CTRL.send(8'h01);
    xfer(8'h0e, NAK);
    ready = 1'b0;
    send_pw(12);
    CTRL.send(8'h03);
    xfer(8'h00, ACK);
    CTRL.send(8'ha1);
    CTRL.send(8'hb2);
    CTRL.send(8'hc3);
    chk_bit(ovr, 1'b1, "overrun");
    chk_word(24'(qa.size()), 24'h00_0000, "write while stalled");
    ready = 1'b1;
    CTRL.send(8'h5a);
    for (int i = 0; i < 500 && n_jump == 0; i++) @(negedge ref_clk_in);
    chk_word(24'(n_jump), 24'h00_0001, "jump pulses");
    chk_word(ja, RAM_LO, "jump address");
    chk_word(24'(qa.size()), 24'h00_0003, "write count");
    for (int i = 0; i < 3 && i < qa.size(); i++)
      chk_word(qa[i], RAM_LO + 24'(i), "write address");
    chk_word({qd[0], qd[1], qd[2]}, 24'ha1_b25a, "write data");
  endtask
  task automatic t_normal();
    m1 = 1'b1;
    addr = 24'hfe_8000;
    do_reset();
    chk_bit(boot, 1'b0, "normal mode");
    chk_bit(inten, 1'b1, "normal interrupts");
    chk_bit(fl, 1'b1, "normal flash");
    addr = 24'hff_f000;
    repeat (2) @(negedge ref_clk_in);
    chk_bit(rom, 1'b0, "no boot rom");
    m0 = 1'b0;
    m1 = 1'b0;
    do_reset();
    chk_bit(boot, 1'b0, "both pins low");
  endtask
  // Rate codes 1, 2, 3 and 7, the partner set to the matching bit time
  task automatic t_rates();
    logic [2:0] rs[4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    int         dv[4] = '{24, 12, 8, 4};
    for (int i = 0; i < 4; i++) begin
      rate = rs[i];
      CTRL.div = dv[i];
      xfer(8'h55, NAK);
    end
    rate = 3'h0;
    CTRL.div = 48;
  endtask
  // Stored password accepted in byte order; erased flag overrides it
  task automatic t_pw();
    CTRL.send(CMD_LOAD);
    for (int i = 0; i < 11; i++) CTRL.send(PW[8*i +: 8]);
    xfer(PW[95:88], ACK);
    CTRL.send(8'h00);
    xfer(8'h00, NAK);
    erased = 1'b1;
    CTRL.send(CMD_LOAD);
    for (int i = 0; i < 11; i++) CTRL.send(PW[8*i +: 8]);
    xfer(PW[95:88], NAK);
  endtask
  initial begin
    m0     = 1'b1;
    m1     = 1'b0;
    erased = 1'b0;
    ready  = 1'b1;
    edone  = 1'b0;
    rate   = 3'h0;
    addr   = 24'h00_0000;
    do_reset();
    t_decode();
    t_rates();
    t_erase();
    send_pw(11);
    xfer(8'hff, NAK);
    t_pw();
    t_load();
    t_normal();
    tally_and_finish();
  end
endmodule // tb_serial_boot_loader
`default_nettype wire
